// [verilog/ihs_ctrl.sv]
// Byte handshake controller for a two-wire bus, master transmitter
`timescale 1ns/1ns
`default_nettype none
`include "ihs_cfg.svh"

// Contract
// - Every bus event sets the operation-complete flag.
// - Interrupt only when flag, local enable and global enable all set.
// - While flag set, status holds the code of the bus state.
// - Writing one to the flag bit clears it; zero leaves it.
// - No bus operation starts while the flag is set.
// - Clearing the flag with start requested begins START at once.
// - After START, flag set and START-sent code posted.
// - After address byte, flag set with ack or nack code.
// - After data byte, flag set with ack or nack code.
// - No flag after a STOP condition.
// - Serial clock held low while flag set.
// - One data register holds address-with-direction or data byte.
// - Status updated one cycle after flag asserted.
// - With flag clear, status shows the no-information code.
module ihs_ctrl #(
	parameter int QUARTER_CYC = `IHS_QUARTER_CYC,
	parameter int BUF_DEPTH = 2
) (
	input wire logic clock_in, // System clock, 100 MHz
	input wire logic rst_in, // Synchronous reset, active high
	input wire logic ctrl_write_in, // Control write strobe
	input wire logic ctrl_flag_clear_in, // Flag bit of control write
	input wire logic ctrl_start_in, // Start request bit
	input wire logic ctrl_stop_in, // Stop request bit
	input wire logic bus_irq_enable_in, // Local interrupt enable
	input wire logic global_irq_enable_in, // Processor global enable
	input wire logic [1:0] prescaler_in, // Prescaler bits shown in status while flag set
	input wire logic data_write_in, // Data register write strobe
	input wire logic [7:0] data_byte_in, // Byte to send
	output logic data_ready_out, // Byte buffer has room
	output logic bus_flag_out, // Operation-complete flag
	output logic [7:0] bus_status_reg_out, // Status code and prescaler
	output logic [7:0] bus_shift_data_reg_out, // Data register readback
	output logic irq_out, // Interrupt request
	input wire logic scl_in, // Serial clock pin level
	output logic scl_out, // Serial clock drive level
	output logic scl_oe_out, // Serial clock drive enable
	input wire logic sda_in, // Serial data pin level
	output logic sda_out, // Serial data drive level
	output logic sda_oe_out // Serial data drive enable
);
	import ihs_pkg::*;

	localparam logic [15:0] QMAX = 16'(QUARTER_CYC - 1);

	ihs_state_type state;
	ihs_phase_type phase;
	logic [15:0] cnt;
	logic [3:0] bit_idx;
	logic [7:0] shifter;
	logic addr_phase;
	logic ack_low;
	logic [7:0] ev_code;
	logic cmd_start;
	logic cmd_stop;
	logic pending;
	logic scl_sync;
	logic sda_sync;
	logic buf_valid;
	logic [7:0] buf_data;

	logic clear_req;
	logic take;
	logic stretch;
	logic quarter_done;
	logic last_phase;
	logic ack_slot;
	logic ev_fire;
	logic [7:0] next_ev_code;
	logic next_flag;
	logic [7:0] next_status;
	logic next_pending;
	logic buf_pop;

	// Pin synchronisers
	ihs_sync3 u_scl_sync (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.async_in(scl_in),
		.level_out(scl_sync)
	);

	ihs_sync3 u_sda_sync (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.async_in(sda_in),
		.level_out(sda_sync)
	);

	// Outgoing byte buffer between data register and shifter
	ihs_fifo2 #(
		.WIDTH(8),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.in_valid_in(data_write_in),
		.in_data_in(data_byte_in),
		.in_ready_out(data_ready_out),
		.out_valid_out(buf_valid),
		.out_data_out(buf_data),
		.out_ready_in(buf_pop)
	);

	assign clear_req = ctrl_write_in & ctrl_flag_clear_in;
	// command taken only with flag clear
	assign take = state[0] & pending & ~bus_flag_out;
	assign next_pending = clear_req | (pending & ~take);

	// Quarter timing; high phase of a byte bit stretched while a slave holds clock low
	assign stretch = state[3] & (phase == 2'h2) & ~scl_sync;
	assign quarter_done = (cnt == 16'h0000) & ~stretch;
	assign last_phase = quarter_done & (phase == 2'h3);
	assign ack_slot = (bit_idx == `IHS_ACK_SLOT);
	assign buf_pop = state[2];

	// event at end of START or of the acknowledge slot
	// STOP completion is not an event
	assign ev_fire = last_phase & (state[1] | (state[3] & ack_slot));

	assign next_ev_code = state[1] ? `IHS_ST_START :
		addr_phase ? (ack_low ? `IHS_ST_SLA_ACK : `IHS_ST_SLA_NACK) :
		(ack_low ? `IHS_ST_DATA_ACK : `IHS_ST_DATA_NACK);

	// Set wins over a clear in the same cycle
	assign next_flag = ev_fire | (bus_flag_out & ~clear_req);

	// code while flag stands; no-info otherwise
	assign next_status = (bus_flag_out & ~clear_req) ?
		(ev_code | {6'h00, prescaler_in}) : `IHS_ST_NOINFO;

	// Control latch, pending command and data readback
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			cmd_start <= 1'b0;
			cmd_stop <= 1'b0;
			pending <= 1'b0;
			bus_shift_data_reg_out <= `IHS_DATA_RESET;
		end else begin
			if (ctrl_write_in) begin
				cmd_start <= ctrl_start_in;
				cmd_stop <= ctrl_stop_in;
			end
			pending <= next_pending;
			// one register for address or data
			if (data_write_in) begin
				bus_shift_data_reg_out <= data_byte_in;
			end
		end
	end

	// Flag, status and interrupt request
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			bus_flag_out <= 1'b0;
			bus_status_reg_out <= `IHS_ST_NOINFO;
			irq_out <= 1'b0;
		end else begin
			bus_flag_out <= next_flag;
			// status follows a rising flag by one cycle; returns to no-info with a clear
			bus_status_reg_out <= next_status;
			// flag and both enables; drops with flag
			irq_out <= next_flag & bus_irq_enable_in & global_irq_enable_in;
		end
	end

	// Quarter counter, reloaded on every phase step
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			cnt <= QMAX;
		end else if (state[0] | state[2] | quarter_done) begin
			cnt <= QMAX;
		end else if (!stretch) begin
			cnt <= cnt - 16'h0001;
		end
	end

	// Pin drive levels are always low; enables do the work
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end
	end

	// Bus engine
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state <= IHS_IDLE;
			phase <= 2'h0;
			bit_idx <= 4'h0;
			shifter <= 8'h00;
			addr_phase <= 1'b0;
			ack_low <= 1'b0;
			ev_code <= `IHS_ST_NOINFO;
			scl_oe_out <= 1'b0;
			sda_oe_out <= 1'b0;
		end else begin
			if (ev_fire) begin
				ev_code <= next_ev_code;
			end
			unique case (state)
				IHS_IDLE: begin
					// clock keeps its drive while waiting: low after START or a byte, released after reset or STOP
					phase <= 2'h0;
					if (take) begin
						if (cmd_start) begin
							state <= IHS_START;
						end else if (cmd_stop) begin
							state <= IHS_STOP;
						end else begin
							state <= IHS_FETCH;
						end
					end
				end
				IHS_START: begin
					if (quarter_done) begin
						phase <= phase + 2'h1;
						unique case (phase)
							2'h0: sda_oe_out <= 1'b0;
							2'h1: scl_oe_out <= 1'b0;
							2'h2: sda_oe_out <= 1'b1;
							default: begin
								scl_oe_out <= 1'b1;
								addr_phase <= 1'b1;
								state <= IHS_IDLE;
							end
						endcase
					end
				end
				IHS_FETCH: begin
					// Waits for a byte; clock keeps its drive meanwhile
					if (buf_valid) begin
						shifter <= buf_data;
						bit_idx <= 4'h0;
						phase <= 2'h0;
						state <= IHS_BITS;
					end
				end
				IHS_BITS: begin
					if (quarter_done) begin
						phase <= phase + 2'h1;
						unique case (phase)
							2'h0: sda_oe_out <= ~ack_slot & ~shifter[7];
							2'h1: scl_oe_out <= 1'b0;
							2'h2: begin
								if (ack_slot) begin
									ack_low <= ~sda_sync;
								end
							end
							default: begin
								scl_oe_out <= 1'b1;
								if (ack_slot) begin
									addr_phase <= 1'b0;
									state <= IHS_IDLE;
								end else begin
									shifter <= {shifter[6:0], 1'b0};
									bit_idx <= bit_idx + 4'h1;
								end
							end
						endcase
					end
				end
				IHS_STOP: begin
					if (quarter_done) begin
						phase <= phase + 2'h1;
						unique case (phase)
							2'h0: sda_oe_out <= 1'b1;
							2'h1: scl_oe_out <= 1'b0;
							2'h2: sda_oe_out <= 1'b0;
							default: begin
								addr_phase <= 1'b0;
								state <= IHS_IDLE;
							end
						endcase
					end
				end
				default: begin
					state <= IHS_IDLE;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// [verilog/ihs_cfg.svh]
// Timing counts, status codes and reset values of the byte handshake controller
`ifndef IHS_CFG_SVH
`define IHS_CFG_SVH

// System clock period in ns
`define IHS_CLK_NS 10
// Quarter of a serial clock period in ns (100 kHz bus)
`define IHS_QUARTER_NS 2500
// Quarter period in clock cycles, rounded down
`define IHS_QUARTER_CYC ((`IHS_QUARTER_NS) / (`IHS_CLK_NS))

// Status codes, upper five bits significant
`define IHS_ST_START 8'h08
`define IHS_ST_SLA_ACK 8'h18
`define IHS_ST_SLA_NACK 8'h20
`define IHS_ST_DATA_ACK 8'h28
`define IHS_ST_DATA_NACK 8'h30
`define IHS_ST_NOINFO 8'hf8

// Position of the acknowledge slot in a byte transfer
`define IHS_ACK_SLOT 4'h8
// Reset value of the data register
`define IHS_DATA_RESET 8'h00

`endif

// [verilog/ihs_pkg.sv]
// Types of the byte handshake controller
package ihs_pkg;

	// Bus engine states, one-hot
	typedef enum logic [4:0] {
		IHS_IDLE = 5'h01,
		IHS_START = 5'h02,
		IHS_FETCH = 5'h04,
		IHS_BITS = 5'h08,
		IHS_STOP = 5'h10
	} ihs_state_type;

	// Quarter phase inside one bus bit
	typedef logic [1:0] ihs_phase_type;

endpackage

// [verilog/ihs_sync3.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module ihs_sync3 (
	input wire logic clock_in, // System clock
	input wire logic rst_in, // Synchronous reset, active high
	input wire logic async_in, // Pin level from outside
	output logic level_out // Filtered level
);

	logic s1;
	logic s2;
	logic s3;
	logic agree;

	// Change accepted once stages two and three agree
	assign agree = (s2 == s3);

	// Shift chain, idle bus reads high
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
			level_out <= 1'b1;
		end else begin
			s1 <= async_in;
			s2 <= s1;
			s3 <= s2;
			if (agree) begin
				level_out <= s3;
			end
		end
	end

endmodule

`default_nettype wire

// [verilog/ihs_fifo2.sv]
// Small valid/ready buffer for outgoing bytes
`timescale 1ns/1ns
`default_nettype none

module ihs_fifo2 #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic clock_in, // System clock
	input wire logic rst_in, // Synchronous reset, active high
	input wire logic in_valid_in, // Word offered
	input wire logic [WIDTH-1:0] in_data_in, // Word to store
	output logic in_ready_out, // Room left, registered
	output logic out_valid_out, // Word available
	output logic [WIDTH-1:0] out_data_out, // Oldest word
	input wire logic out_ready_in // Drain side takes the word
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic push;
	logic pop;
	logic [PW-1:0] wr_ptr_inc;
	logic [PW-1:0] rd_ptr_inc;

	// Handshakes on both sides
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;
	assign out_valid_out = (count != '0);
	assign out_data_out = mem[rd_ptr];
	assign next_count = count + CW'(push) - CW'(pop);
	assign wr_ptr_inc = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
	assign rd_ptr_inc = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

	// Storage
	always_ff @(posedge clock_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

	// Pointers, fill level and registered room flag
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_out <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr_inc;
			end
			if (pop) begin
				rd_ptr <= rd_ptr_inc;
			end
			count <= next_count;
			in_ready_out <= (next_count != CW'(DEPTH));
		end
	end

endmodule

`default_nettype wire

// [dv/ihs_ctrl_asserts.sv]
// Port checker for the byte handshake controller
`timescale 1ns/1ns
`default_nettype none

module ihs_chk #(
	parameter int QUARTER_CYC = 250
) (
	input wire logic clock_in, // Clock
	input wire logic rst_in, // Reset
	input wire logic ctrl_write_in, // Control write
	input wire logic ctrl_flag_clear_in, // Clear bit
	input wire logic ctrl_start_in, // Start bit
	input wire logic ctrl_stop_in, // Stop bit
	input wire logic bus_irq_enable_in, // Local enable
	input wire logic global_irq_enable_in, // Global enable
	input wire logic data_write_in, // Data write
	input wire logic [7:0] data_byte_in, // Data byte
	input wire logic data_ready_out, // Buffer room
	input wire logic bus_flag_out, // Flag
	input wire logic [7:0] bus_status_reg_out, // Status
	input wire logic [7:0] bus_shift_data_reg_out, // Readback
	input wire logic irq_out, // Interrupt
	input wire logic scl_oe_out, // Clock pull
	input wire logic sda_oe_out // Data pull
);
	localparam int SMAX = (QUARTER_CYC > 60) ? 1000 : 5 * QUARTER_CYC + 20;
	wire clr_w = ctrl_write_in && ctrl_flag_clear_in;
	logic stop_run;

	default clocking @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	// Stop command pending until the next clearing write
	always_ff @(posedge clock_in) begin
		if (rst_in)
			stop_run <= 1'h0;
		else if (clr_w)
			stop_run <= ctrl_stop_in && !ctrl_start_in;
	end

	irq_gate_a: assert property (irq_out |-> bus_flag_out &&
		$past(bus_irq_enable_in && global_irq_enable_in))
		else $error("irq without cause");
	clear_drop_a: assert property (clr_w && bus_flag_out |=>
		!bus_flag_out && !irq_out && bus_status_reg_out == 8'hf8)
		else $error("clear failed");
	idle_code_a: assert property (!bus_flag_out |->
		bus_status_reg_out == 8'hf8) else $error("status not idle");
	status_late_a: assert property ($rose(bus_flag_out) |->
		bus_status_reg_out == 8'hf8 ##1 !bus_status_reg_out[2] &&
		bus_status_reg_out[7:3] != 5'h1f) else $error("status timing");
	code_set_a: assert property (bus_flag_out && $past(bus_flag_out) |->
		bus_status_reg_out[7:3] inside {5'h01, 5'h03, 5'h04, 5'h05, 5'h06})
		else $error("bad code");
	scl_hold_a: assert property (bus_flag_out |-> scl_oe_out)
		else $error("clock not held");
	bus_still_a: assert property (bus_flag_out && !clr_w |=>
		$stable(scl_oe_out) && $stable(sda_oe_out)) else $error("bus moved");
	start_done_a: assert property (clr_w && ctrl_start_in |->
		##[2:SMAX] $rose(bus_flag_out) ##1 bus_status_reg_out[7:3] == 5'h01)
		else $error("start late");
	stop_quiet_a: assert property (stop_run |-> !bus_flag_out)
		else $error("flag after stop");
	data_back_a: assert property (data_write_in && data_ready_out |=>
		bus_shift_data_reg_out == $past(data_byte_in)) else $error("data lost");

	cover property ($rose(irq_out));
	cover property ($rose(bus_flag_out) ##1 bus_status_reg_out[7:3] == 5'h06);
	cover property (data_write_in && !data_ready_out);
endmodule

bind ihs_ctrl ihs_chk #(.QUARTER_CYC(QUARTER_CYC)) chk (.clock_in, .rst_in,
	.ctrl_write_in, .ctrl_flag_clear_in, .ctrl_start_in, .ctrl_stop_in,
	.bus_irq_enable_in, .global_irq_enable_in, .data_write_in, .data_byte_in,
	.data_ready_out, .bus_flag_out, .bus_status_reg_out,
	.bus_shift_data_reg_out, .irq_out, .scl_oe_out, .sda_oe_out);

`default_nettype wire

// [dv/ihs_slave.sv]
// Behavioural bus slave that acknowledges and may stretch
`timescale 1ns/1ns
`default_nettype none

module ihs_slave (
	input wire logic scl_in, // Clock line
	input wire logic sda_in, // Data line
	input wire logic ack_en_in, // Acknowledge
	input wire logic stretch_in, // Stretch before ack
	output logic scl_oe_out, // Pull clock low
	output logic sda_oe_out, // Pull data low
	output logic [7:0] rx_byte_out // Last byte
);
	int n = 0;
	logic [7:0] sh = 8'h00;

	initial begin
		scl_oe_out = 1'h0;
		sda_oe_out = 1'h0;
		rx_byte_out = 8'h00;
	end
	// Start condition restarts the count
	always @(negedge sda_in)
		if (scl_in === 1'h1)
			n = 0;
	// Shift on rising clock
	always @(posedge scl_in) begin
		sh = {sh[6:0], sda_in};
		n = n + 1;
		if (n == 8)
			rx_byte_out = sh;
	end
	// Ack slot, optional stretch, then release
	always @(negedge scl_in) begin
		if (n == 8) begin
			sda_oe_out = ack_en_in;
			if (stretch_in) begin
				scl_oe_out = 1'h1;
				#500 scl_oe_out = 1'h0;
			end
		end else if (n == 9) begin
			sda_oe_out = 1'h0;
			n = 0;
		end
	end
endmodule

`default_nettype wire

// [dv/ihs_ctrl_tb.sv]
// Self-checking bench: controller against a behavioural slave
`timescale 1ns/1ns
`default_nettype none

module ihs_ctrl_tb;
	logic clock_in, rst_in, cw, cc, cs, cp, ie, ge, dw, ack, str;
	logic rdy, flag, irq, scl_e, sda_e, s_scl_e, s_sda_e, fp, fpp, so, sd;
	logic [1:0] pre;
	logic [7:0] db, st, rd, rx, a, d0, d1;
	logic [7:0] q_st[$], q_by[$];
	int n_mismatch = 0, n_checks = 0, cyc = 0;
	integer seed = 32'h8e5bcfa6;
	// Open-drain lines with pull-ups
	wire scl = ~(scl_e | s_scl_e);
	wire sda = ~(sda_e | s_sda_e);

	ihs_ctrl #(.QUARTER_CYC(4)) uut (.clock_in, .rst_in, .ctrl_write_in(cw),
		.ctrl_flag_clear_in(cc), .ctrl_start_in(cs), .ctrl_stop_in(cp),
		.bus_irq_enable_in(ie), .global_irq_enable_in(ge), .prescaler_in(pre),
		.data_write_in(dw), .data_byte_in(db), .data_ready_out(rdy),
		.bus_flag_out(flag), .bus_status_reg_out(st),
		.bus_shift_data_reg_out(rd), .irq_out(irq), .scl_in(scl), .scl_out(so),
		.scl_oe_out(scl_e), .sda_in(sda), .sda_out(sd), .sda_oe_out(sda_e));
	ihs_slave sl (.scl_in(scl), .sda_in(sda), .ack_en_in(ack),
		.stretch_in(str), .scl_oe_out(s_scl_e), .sda_oe_out(s_sda_e),
		.rx_byte_out(rx));

	initial begin
		clock_in = 1'h0;
		forever #5 clock_in = ~clock_in;
	end

	task automatic chk(input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (n_mismatch == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// One-cycle control write
	task automatic ctl(input logic c, s, p);
		@(negedge clock_in);
		{cc, cs, cp, cw} = {c, s, p, 1'h1};
		@(negedge clock_in);
		cw = 1'h0;
	endtask

	// One-cycle data write
	task automatic dat(input logic [7:0] b);
		@(negedge clock_in);
		{db, dw} = {b, 1'h1};
		@(negedge clock_in);
		dw = 1'h0;
	endtask

	// Note the outcome, clear the flag with a command, await the event
	task automatic step(input logic s, p, input logic [7:0] code, b);
		@(negedge clock_in);
		pre = 2'($random(seed));
		str = 1'($random(seed));
		q_st.push_back(code | {6'h00, pre});
		q_by.push_back(b);
		ctl(1'h1, s, p);
		repeat (3) @(negedge clock_in);
		for (int k = 0; k < 3000 && flag !== 1'h1; k++)
			@(negedge clock_in);
		chk(flag, 1'h1);
	endtask

	always @(negedge clock_in) begin
		if (flag === 1'h1 && fp === 1'h1 && fpp !== 1'h1) begin
			chk(st, q_st[0]);
			if (q_st[0][7:3] != 5'h01)
				chk(rx, q_by[0]);
			void'(q_st.pop_front());
			void'(q_by.pop_front());
		end
		fpp = fp;
		fp = flag;
	end

	// Hang limit
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	initial begin
		{cw, cc, cs, cp, dw, db, pre} = 15'h0;
		{ie, ge, ack, str} = 4'he;
		rst_in = 1'h1;
		repeat (10) @(negedge clock_in);
		rst_in = 1'h0;
		chk(st, 8'hf8);
		chk({flag, irq, rdy, rd[4:0]}, 8'h20);
		// start, then a write that keeps the flag
		step(1'h1, 1'h0, 8'h08, 8'h00);
		chk(irq, 1'h1);
		ctl(1'h0, 1'h1, 1'h0);
		repeat (40) @(negedge clock_in);
		chk({flag, scl, sda}, 8'h04);
		// address, fill buffer, refused write, data
		a = {7'($random(seed)), 1'h0};
		d0 = 8'($random(seed));
		d1 = 8'($random(seed));
		dat(a);
		step(1'h0, 1'h0, 8'h18, a);
		dat(d0);
		dat(d1);
		chk({rdy, rd}, {1'h0, d1});
		dat(~d1);
		step(1'h0, 1'h0, 8'h28, d0);
		step(1'h0, 1'h0, 8'h28, d1);
		ctl(1'h1, 1'h0, 1'h1);
		repeat (150) @(negedge clock_in);
		chk({flag, rdy, scl, sda}, 8'h07);
		for (int i = 0; i < 4; i++) begin
			{ie, ge} = 2'(i);
			ack = i[0];
			a = {7'($random(seed)), 1'h0};
			step(1'h1, i[1], 8'h08, 8'h00);
			chk(irq, i == 3);
			dat(a);
			step(1'h0, 1'h0, ack ? 8'h18 : 8'h20, a);
			dat(~a);
			step(1'h0, 1'h0, ack ? 8'h28 : 8'h30, ~a);
		end
		ctl(1'h1, 1'h0, 1'h1);
		repeat (150) @(negedge clock_in);
		chk({flag, rdy, scl, sda}, 8'h07);
		chk(q_st.size(), 0);
		chk({so, sd}, 2'h0);
		report_and_stop();
	end
endmodule

`default_nettype wire
